/* hw/srw_top.sv */
// sysref capture, window flags and automatic delay calibration
`timescale 1ns/100ps
`include "srw_consts.svh"
module srw_top (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic [23:0]      sysref_tap,
    input  wire logic             sysref_fall_late,
    input  wire logic [3:0]       capture_position_select,
    input  wire logic             window_step_fine,
    input  wire logic             autocal_start,
    input  wire logic [7:0]       autocal_config,
    input  wire logic             manual_write,
    input  wire logic             manual_invert,
    input  wire srw_pkg::srw_delay_t manual_coarse,
    input  wire srw_pkg::srw_delay_t manual_fine,
    output logic [7:0]            window_flags_low,
    output logic [7:0]            window_flags_mid,
    output logic [7:0]            window_flags_high,
    output logic                  window_flags_valid,
    output logic                  step_fine_ctl,
    output logic                  sysref_capture,
    output logic                  delay_clock_invert,
    output srw_pkg::srw_delay_t   delay_coarse,
    output srw_pkg::srw_delay_t   delay_fine,
    output logic [16:0]           autocal_result_delay,
    output logic                  autocal_done,
    output logic                  autocal_busy
);
    import srw_pkg::*;

    logic [23:0] flags_w;
    logic        flags_valid_w;
    logic        rise_w;

    srw_window_det u_win (
        .sys_clk       (sys_clk),
        .rst_b         (rst_b),
        .sysref_tap    (sysref_tap),
        .flags_q       (flags_w),
        .flags_valid_q (flags_valid_w),
        .rise_q        (rise_w)
    );

    srw_state_t state_ff;
    srw_state_t nxt_state;
    logic       start_prev_ff;
    logic [7:0] wait_ff;
    logic       found0_ff;
    srw_delay_t c0_ff;
    logic       nxt_inv;
    srw_delay_t nxt_coarse;
    srw_delay_t nxt_fine;
    srw_delay_t nxt_c0;
    logic       nxt_found0;
    logic [7:0] nxt_wait;

    // decode of the calibration events
    wire start_rise  = autocal_start & ~start_prev_ff;
    wire sweeping    = (state_ff == SRW_SWEEP);
    wire stop_req    = sweeping & ~autocal_start;
    wire settled     = (wait_ff >= autocal_config);
    wire eval        = sweeping & autocal_start & rise_w & settled;
    wire hit         = eval & sysref_fall_late;
    wire at_end      = (delay_coarse == `SRW_COARSE_MAX);
    wire polarity_ok = hit | (eval & at_end);
    wire finish      = polarity_ok & delay_clock_invert;
    // candidate from the inverted sweep, then the smaller coarse wins
    wire found1      = hit & delay_clock_invert;
    wire take0       = found0_ff & (~found1 | (c0_ff <= delay_coarse));
    wire pick_inv    = ~take0 & found1;
    wire srw_delay_t pick_coarse = take0 ? c0_ff : (found1 ? delay_coarse : `SRW_DELAY_RST);
    wire manual_load = manual_write & ~autocal_start & ~sweeping;

    always_comb begin
        nxt_state  = state_ff;
        nxt_inv    = delay_clock_invert;
        nxt_coarse = delay_coarse;
        nxt_fine   = delay_fine;
        nxt_c0     = c0_ff;
        nxt_found0 = found0_ff;
        nxt_wait   = wait_ff;
        if (start_rise) begin
            nxt_state  = SRW_SWEEP;
            nxt_inv    = 1'b0;
            nxt_coarse = `SRW_DELAY_RST;
            nxt_fine   = `SRW_DELAY_RST;
            nxt_found0 = 1'b0;
            nxt_wait   = 8'h00;
        end else if (stop_req) begin
            nxt_state = SRW_IDLE; // RQ23
        end else if (finish) begin
            nxt_state  = SRW_DONE; // RQ15
            nxt_inv    = pick_inv; // RQ16
            nxt_coarse = pick_coarse; // RQ16
        end else if (polarity_ok) begin
            nxt_found0 = hit; // RQ16
            nxt_c0     = delay_coarse;
            nxt_inv    = 1'b1;
            nxt_coarse = `SRW_DELAY_RST;
            nxt_wait   = 8'h00;
        end else if (eval) begin
            nxt_coarse = delay_coarse + 8'h01; // RQ15
            nxt_wait   = 8'h00;
        end else if (sweeping & rise_w) begin
            nxt_wait = wait_ff + 8'h01;
        end else if (manual_load) begin
            nxt_inv    = manual_invert; // RQ20 RQ21
            nxt_coarse = manual_coarse; // RQ21
            nxt_fine   = manual_fine; // RQ21
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_ff      <= SRW_IDLE;
            start_prev_ff <= 1'b0;
            wait_ff       <= 8'h00;
            found0_ff     <= 1'b0;
            c0_ff         <= `SRW_DELAY_RST;
        end else begin
            state_ff      <= nxt_state;
            start_prev_ff <= autocal_start;
            wait_ff       <= nxt_wait;
            found0_ff     <= nxt_found0;
            c0_ff         <= nxt_c0;
        end
    end

    // applied delay fields drive the analog delay cells separately
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            delay_clock_invert <= 1'b0;
            delay_coarse       <= `SRW_DELAY_RST;
            delay_fine         <= `SRW_DELAY_RST;
        end else begin
            delay_clock_invert <= nxt_inv; // RQ20
            delay_coarse       <= nxt_coarse;
            delay_fine         <= nxt_fine;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            autocal_done         <= 1'b0;
            autocal_busy         <= 1'b0;
            autocal_result_delay <= 17'h00000;
        end else begin
            autocal_busy <= (nxt_state == SRW_SWEEP);
            if (start_rise) begin
                autocal_done <= 1'b0; // RQ22
            end else if (finish & ~stop_req) begin
                autocal_done         <= 1'b1; // RQ15
                autocal_result_delay <= {pick_inv, pick_coarse, delay_fine}; // RQ17
            end
        end
    end

    // flag readout, step control and the sysref capture flop
    wire capture_tap = sysref_tap[capture_position_select]; // RQ6 RQ7

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            window_flags_low   <= 8'hff;
            window_flags_mid   <= 8'hff;
            window_flags_high  <= 8'hff;
            window_flags_valid <= 1'b0;
            step_fine_ctl      <= 1'b0;
            sysref_capture     <= 1'b0;
        end else begin
            window_flags_low   <= flags_w[7:0]; // RQ3
            window_flags_mid   <= flags_w[15:8];
            window_flags_high  <= flags_w[23:16];
            window_flags_valid <= flags_valid_w;
            step_fine_ctl      <= window_step_fine; // RQ8
            sysref_capture     <= capture_tap; // RQ1 RQ2
        end
    end

    chk_capture_selected_tap: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ##1 sysref_capture == $past(sysref_tap[capture_position_select])) // RQ2
        else $error("capture does not follow selected tap");
    chk_step_follows_ctl: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ##1 step_fine_ctl == $past(window_step_fine)) // RQ8
        else $error("step control not applied");
    chk_done_clears_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
        start_rise |=> !autocal_done && autocal_busy) // RQ22
        else $error("done not cleared on new start");
    chk_stop_holds_delay: assert property (@(posedge sys_clk) disable iff (!rst_b)
        stop_req |=> state_ff == SRW_IDLE && $stable(delay_coarse) && $stable(delay_fine)) // RQ23
        else $error("stop changed delay or kept searching");
    chk_done_after_sweep: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(autocal_done) |-> $past(state_ff) == SRW_SWEEP && state_ff == SRW_DONE) // RQ15
        else $error("done raised without a search");
    chk_result_is_applied: assert property (@(posedge sys_clk) disable iff (!rst_b)
        autocal_done && autocal_start && !start_rise
        |-> autocal_result_delay == {delay_clock_invert, delay_coarse, delay_fine}) // RQ17
        else $error("result differs from applied delay");
    chk_pick_smallest: assert property (@(posedge sys_clk) disable iff (!rst_b)
        finish && !stop_req && found0_ff |=> delay_coarse <= $past(c0_ff)) // RQ16
        else $error("larger coarse delay chosen");
endmodule : srw_top

/* inc/srw_consts.svh */
// constants for the sysref window and automatic calibration block
// Notes on behaviour
// (RQ1) sysref latched on one fixed clock edge
// (RQ2) capture instant chosen among delayed clock copies
// (RQ3) flags measured, valid after three sysref rises
// (RQ4) flag one means risky, zero means usable
// (RQ5) flag bits zero and 23 always one
// (RQ6) select field holds decimal flag index
// (RQ7) select reaches positions 0 to 15 only
// (RQ8) step control: zero coarse, one fine
// (RQ9) software should keep fine steps selected
// (RQ10) software picks middle, prefers low indexes
// (RQ11) software sets select zero during calibration
// (RQ12) clock applied, device configured before calibration
// (RQ13) sysref must be periodic during calibration
// (RQ14) write config first, then set start
// (RQ15) search delays until edges align, then done
// (RQ16) try both polarities, keep smallest coarse delay
// (RQ17) result exposed and kept in use
// (RQ18) software may load stored delay fields
// (RQ19) no converter calibration during sysref calibration
// (RQ20) invert option adds half clock period
// (RQ21) invert, coarse, fine act independently, add up
// (RQ22) flags refresh continuously; done clears on start
// (RQ23) clearing start stops search, keeps delay
`ifndef SRW_CONSTS_SVH
`define SRW_CONSTS_SVH
`define SRW_FLAGS_LOW_OFS   8'h2c
`define SRW_FLAGS_MID_OFS   8'h2d
`define SRW_FLAGS_HIGH_OFS  8'h2e
`define SRW_NUM_POS         24
`define SRW_LAST_POS        23
`define SRW_FLAGS_RST       24'hffffff
`define SRW_EDGE_FLAGS      24'h800001
`define SRW_EDGES_LAST      2'h2
`define SRW_COARSE_MAX      8'hff
`define SRW_DELAY_RST       8'h00
`endif

/* inc/srw_pkg.sv */
// types shared by the sysref window and calibration block
package srw_pkg;
    typedef logic [7:0] srw_delay_t;
    typedef enum logic [1:0] {
        SRW_IDLE  = 2'b00,
        SRW_SWEEP = 2'b01,
        SRW_DONE  = 2'b10
    } srw_state_t;
endpackage : srw_pkg

/* hw/srw_window_det.sv */
// sysref position detector over the delayed sampling taps
`timescale 1ns/100ps
`include "srw_consts.svh"
module srw_window_det (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [23:0] sysref_tap,
    output logic      [23:0] flags_q,
    output logic             flags_valid_q,
    output logic             rise_q
);
    import srw_pkg::*;

    logic        prev0_ff;
    logic [23:0] acc_ff;
    logic [1:0]  cnt_ff;
    logic [1:0]  seen_ff;
    wire         rise_now = sysref_tap[0] & ~prev0_ff;
    wire  [23:0] edge_bits;

    // a tap disagreeing with a neighbour sits on the sysref edge
    genvar i;
    generate
        for (i = 0; i < `SRW_NUM_POS; i = i + 1) begin : g_pos
            if (i == 0 || i == `SRW_LAST_POS) begin : g_end
                assign edge_bits[i] = 1'b1; // RQ5
            end else begin : g_mid
                assign edge_bits[i] = (sysref_tap[i] ^ sysref_tap[i-1]) |
                                      (sysref_tap[i] ^ sysref_tap[i+1]); // RQ4
            end
        end
    endgenerate

    wire [23:0] nxt_acc = acc_ff | edge_bits;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            prev0_ff      <= 1'b0;
            acc_ff        <= 24'h000000;
            cnt_ff        <= 2'h0;
            seen_ff       <= 2'h0;
            flags_q       <= `SRW_FLAGS_RST;
            flags_valid_q <= 1'b0;
            rise_q        <= 1'b0;
        end else begin
            prev0_ff <= sysref_tap[0];
            rise_q   <= rise_now;
            if (rise_now) begin
                if (seen_ff != 2'h3) begin
                    seen_ff <= seen_ff + 2'h1;
                end
                if (cnt_ff == `SRW_EDGES_LAST) begin
                    flags_q       <= nxt_acc; // RQ3 RQ22
                    flags_valid_q <= 1'b1;
                    acc_ff        <= 24'h000000;
                    cnt_ff        <= 2'h0;
                end else begin
                    acc_ff <= nxt_acc;
                    cnt_ff <= cnt_ff + 2'h1;
                end
            end
        end
    end

    chk_edge_bits_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (flags_q & `SRW_EDGE_FLAGS) == `SRW_EDGE_FLAGS) // RQ5
        else $error("edge flag bits not set");
    chk_valid_three_edges: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(flags_valid_q) |-> $past(seen_ff) == 2'h2 && $past(rise_now)) // RQ3
        else $error("flags valid before third sysref rise");
    chk_flag_risky_tap: assert property (@(posedge sys_clk) disable iff (!rst_b)
        rise_now && cnt_ff == `SRW_EDGES_LAST && sysref_tap[5] != sysref_tap[4]
        |=> flags_q[5] && flags_q[4]) // RQ4
        else $error("edge position not flagged");
endmodule : srw_window_det

/* verif/srw_clk_src.sv */
// clock source model: periodic sysref on the delayed taps and a phase detector
`timescale 1ns/100ps
module srw_clk_src #(
    parameter int PERIOD = 8
) (
    input  wire logic        sys_clk,
    input  wire logic        run,
    input  wire logic [4:0]  edge_pos,
    input  wire logic        delay_clock_invert,
    input  wire logic [7:0]  delay_coarse,
    input  wire logic [8:0]  target_norm,
    input  wire logic [8:0]  target_inv,
    output logic      [23:0] sysref_tap,
    output logic             sysref_fall_late
);
    int phase_cnt = 0;
    initial begin
        sysref_tap = 24'h000000;
        sysref_fall_late = 1'b0;
    end
    always @(posedge sys_clk) begin
        phase_cnt <= run ? (phase_cnt + 1) % PERIOD : 0;
        // the rise cycle shows the edge between taps edge_pos-1 and edge_pos
        if (!run)
            sysref_tap <= 24'h000000;
        else if (phase_cnt == 0)
            sysref_tap <= (24'h000001 << edge_pos) - 24'h000001;
        else if (phase_cnt < PERIOD / 2)
            sysref_tap <= 24'hffffff;
        else
            sysref_tap <= 24'h000000;
        // more delay moves the internal falling edge past the sysref rise
        sysref_fall_late <= delay_clock_invert ? ({1'b0, delay_coarse} >= target_inv)
                                               : ({1'b0, delay_coarse} >= target_norm);
    end
endmodule : srw_clk_src

/* verif/srw_top_tb_top.sv */
// self-checking bench for the sysref window and calibration block
`timescale 1ns/100ps
module srw_top_tb_top;
    import srw_pkg::*;
    logic sys_clk = 0, rst_b = 0, window_step_fine = 0, autocal_start = 0;
    logic manual_write = 0, manual_invert = 0, src_run = 0, tap0_prev = 0;
    logic exp_cap, exp_step, window_flags_valid, step_fine_ctl, sysref_capture;
    logic delay_clock_invert, autocal_done, autocal_busy, sysref_fall_late;
    logic [3:0] capture_position_select = 4'h0;
    logic [4:0] edge_pos = 5'h05;
    logic [7:0] autocal_config = 8'h00, window_flags_low, window_flags_mid, window_flags_high;
    logic [8:0] target_norm = 9'h000, target_inv = 9'h000;
    logic [16:0] autocal_result_delay, exp_res;
    logic [23:0] sysref_tap, flags, mask;
    srw_delay_t manual_coarse = 8'h00, manual_fine = 8'h00, delay_coarse, delay_fine;
    int failures = 0, num_checks = 0, seed = 13, rise_cnt = 0, pos, t0, t1;
    int t0s[4] = '{5, 4, 0, 300};
    int t1s[4] = '{3, 4, 9, 300};
    assign flags = {window_flags_high, window_flags_mid, window_flags_low};
    always #5 sys_clk = ~sys_clk;
    srw_clk_src src (.sys_clk(sys_clk), .run(src_run), .edge_pos(edge_pos),
        .delay_clock_invert(delay_clock_invert), .delay_coarse(delay_coarse),
        .target_norm(target_norm), .target_inv(target_inv), .sysref_tap(sysref_tap),
        .sysref_fall_late(sysref_fall_late));
    srw_top uut (.sys_clk(sys_clk), .rst_b(rst_b), .sysref_tap(sysref_tap),
        .sysref_fall_late(sysref_fall_late), .capture_position_select(capture_position_select),
        .window_step_fine(window_step_fine), .autocal_start(autocal_start),
        .autocal_config(autocal_config), .manual_write(manual_write),
        .manual_invert(manual_invert), .manual_coarse(manual_coarse), .manual_fine(manual_fine),
        .window_flags_low(window_flags_low), .window_flags_mid(window_flags_mid),
        .window_flags_high(window_flags_high), .window_flags_valid(window_flags_valid),
        .step_fine_ctl(step_fine_ctl), .sysref_capture(sysref_capture),
        .delay_clock_invert(delay_clock_invert), .delay_coarse(delay_coarse),
        .delay_fine(delay_fine), .autocal_result_delay(autocal_result_delay),
        .autocal_done(autocal_done), .autocal_busy(autocal_busy));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wait_rise(input int n);
        for (int i = 0; i < 40 && rise_cnt < n; i++) @(posedge sys_clk);
    endtask : wait_rise
    task automatic complete_run;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run
    always @(posedge sys_clk) begin
        tap0_prev <= sysref_tap[0];
        if (sysref_tap[0] && !tap0_prev) rise_cnt <= rise_cnt + 1;
        exp_cap <= rst_b & sysref_tap[capture_position_select];
        exp_step <= rst_b & window_step_fine;
    end
    always @(negedge sys_clk) begin
        chk({22'h0, sysref_capture, step_fine_ctl}, {22'h0, exp_cap, exp_step}, "capture");
    end
    initial begin
        #500000;
        failures++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(negedge sys_clk);
        chk({flags[22:0], window_flags_valid}, 24'hfffffe, "reset flags");
        @(posedge sys_clk);
        src_run <= 1'b1;
        wait_rise(2);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({23'h0, window_flags_valid}, 24'h0, "valid early");
        wait_rise(3);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({23'h0, window_flags_valid}, 24'h1, "valid");
        for (int t = 0; t < 4; t++) begin
            pos = 3 + ($unsigned($random(seed)) % 18);
            @(posedge sys_clk);
            edge_pos <= pos[4:0];
            capture_position_select <= 4'($random(seed));
            window_step_fine <= 1'($random(seed));
            repeat (64) @(posedge sys_clk);
            @(negedge sys_clk);
            mask = 24'h7ffffe & ~(24'h000003 << (pos - 1));
            chk({22'h0, flags[23], flags[0]}, 24'h3, "edge flags");
            chk(flags & mask, 24'h0, "usable flags");
            chk({23'h0, |(flags & ~mask & 24'h7ffffe)}, 24'h1, "risky flag");
        end
        $display("test window done at %0t", $time);
        @(posedge sys_clk);
        capture_position_select <= 4'(pos / 2);
        window_step_fine <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            t0 = t0s[c];
            t1 = t1s[c];
            @(posedge sys_clk);
            capture_position_select <= 4'h0;
            target_norm <= t0[8:0];
            target_inv <= t1[8:0];
            autocal_config <= (c == 1) ? 8'h01 : 8'h00;
            @(posedge sys_clk);
            autocal_start <= 1'b1;
            manual_write <= 1'b1;
            manual_coarse <= 8'hee;
            @(posedge sys_clk);
            manual_write <= 1'b0;
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            chk({22'h0, autocal_busy, autocal_done}, 24'h2, "cal started");
            chk({23'h0, delay_coarse == 8'hee}, 24'h0, "load refused");
            for (int i = 0; i < 6000 && autocal_done !== 1'b1; i++) @(posedge sys_clk);
            @(negedge sys_clk);
            exp_res[16] = (t1 <= 255) && (t0 > 255 || t1 < t0);
            exp_res[15:8] = exp_res[16] ? t1[7:0] : (t0 <= 255) ? t0[7:0] : 8'h00;
            exp_res[7:0] = 8'h00;
            chk({22'h0, autocal_busy, autocal_done}, 24'h1, "cal done");
            chk({7'h0, autocal_result_delay}, {7'h0, exp_res}, "result");
            chk({7'h0, delay_clock_invert, delay_coarse, delay_fine}, {7'h0, exp_res}, "delay");
            @(posedge sys_clk);
            autocal_start <= 1'b0;
            repeat (4) @(posedge sys_clk);
            @(negedge sys_clk);
            chk({6'h0, autocal_done, delay_clock_invert, delay_coarse, delay_fine},
                {6'h0, 1'b1, exp_res}, "held");
        end
        $display("test calibration done at %0t", $time);
        @(posedge sys_clk);
        target_norm <= 9'h0c8;
        target_inv <= 9'h0c8;
        autocal_start <= 1'b1;
        repeat (40) @(posedge sys_clk);
        autocal_start <= 1'b0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        exp_res = {delay_clock_invert, delay_coarse, delay_fine};
        chk({23'h0, autocal_busy}, 24'h0, "abort");
        repeat (24) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({7'h0, delay_clock_invert, delay_coarse, delay_fine}, {7'h0, exp_res}, "abort hold");
        $display("test abort done at %0t", $time);
        for (int m = 0; m < 3; m++) begin
            exp_res = 17'($random(seed));
            @(posedge sys_clk);
            manual_write <= 1'b1;
            {manual_invert, manual_coarse, manual_fine} <= exp_res;
            @(posedge sys_clk);
            manual_write <= 1'b0;
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            chk({7'h0, delay_clock_invert, delay_coarse, delay_fine}, {7'h0, exp_res}, "manual");
        end
        $display("test manual delay done at %0t", $time);
        complete_run();
    end
endmodule : srw_top_tb_top
